// ===== design/scan_pkg.sv
/*
  Constants shared by the gate-scan shift register and its output buffer.
  Assumes a single 100 MHz system clock domain.
*/
package scan_pkg;
  localparam int STAGES = 120;
  localparam int LAST = STAGES - 1;
  localparam int BUF_DEPTH = 2;
  localparam int BUF_WIDTH = 1;
  localparam logic [STAGES-1:0] CHAIN_RESET = '0;
  localparam logic [1:0] CNT_EMPTY = 2'h0;
  localparam logic [1:0] CNT_ONE = 2'h1;
  localparam logic [1:0] CNT_FULL = 2'h2;
endpackage

// ===== design/bit_buffer2.sv
/*
  Two-entry buffer with valid/ready on both sides.
  Assumes the filling side holds data stable only for the cycle it is taken.
*/
`timescale 1ns/100ps
module bit_buffer2 (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [scan_pkg::BUF_WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [scan_pkg::BUF_WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [scan_pkg::BUF_DEPTH-1:0][scan_pkg::BUF_WIDTH-1:0] mem;
    logic rd_ptr;
    logic wr_ptr;
    logic [1:0] cnt;
  } buf_state_t;

  buf_state_t st_r;
  buf_state_t st_nxt;
  logic push;
  logic pop;

  // Handshakes; full and empty come straight from the count
  assign in_ready = (st_r.cnt != scan_pkg::CNT_FULL);
  assign out_valid = (st_r.cnt != scan_pkg::CNT_EMPTY);
  assign out_data = st_r.mem[st_r.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next state: write at wr_ptr, read at rd_ptr
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wr_ptr] = in_data;
      st_nxt.wr_ptr = ~st_r.wr_ptr;
    end
    if (pop) begin
      st_nxt.rd_ptr = ~st_r.rd_ptr;
    end
    if (push && !pop) begin
      st_nxt.cnt = st_r.cnt + scan_pkg::CNT_ONE;
    end else if (pop && !push) begin
      st_nxt.cnt = st_r.cnt - scan_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// ===== design/gate_scan_shift.sv
/*
  Bidirectional 120-stage gate-scan shift register, oversampled on sys_clk.
  Assumes shift_clock, direction_select, output_clear and both end ports are
  asynchronous pins far slower than sys_clk (shift clock at most 100 kHz).
*/
// Overview of operation
// - 120 stages, one gate output each
// - Rising shift clock captures selected input port
// - Each rising edge advances pattern one stage
// - Leaving bit shown on falling shift clock
// - Select high: first port in, second out
// - Select low: second port in, first out
// - Clear high forces all gate outputs low
// - Clear low: gate outputs mirror the stages
`timescale 1ns/100ps
module gate_scan_shift (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic shift_clock,
  input wire logic direction_select,
  input wire logic output_clear,
  input wire logic first_end_port_in,
  output logic first_end_port_out,
  output logic first_end_port_oe,
  input wire logic second_end_port_in,
  output logic second_end_port_out,
  output logic second_end_port_oe,
  output logic [scan_pkg::STAGES-1:0] gate_outputs
);
  typedef struct packed {
    logic sck_s1;
    logic sck_s2;
    logic sck_d;
    logic dir_s1;
    logic dir_s2;
    logic clr_s1;
    logic clr_s2;
    logic p1_s1;
    logic p1_s2;
    logic p2_s1;
    logic p2_s2;
    logic [scan_pkg::STAGES-1:0] chain;
    logic [scan_pkg::STAGES-1:0] gate;
    logic out_bit;
    logic oe1;
    logic oe2;
  } scan_state_t;

  scan_state_t st_r;
  scan_state_t st_nxt;
  logic rise;
  logic fall;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_data;
  logic leave_bit;

  // One shift step; dir high moves data toward the top stage
  function automatic logic [scan_pkg::STAGES-1:0] shift_step(
    input logic [scan_pkg::STAGES-1:0] v,
    input logic dir,
    input logic din
  );
    if (dir) begin
      shift_step = {v[scan_pkg::LAST-1:0], din};
    end else begin
      shift_step = {din, v[scan_pkg::LAST:1]};
    end
  endfunction

  // The stage at the output end for the given direction
  function automatic logic last_stage(
    input logic [scan_pkg::STAGES-1:0] v,
    input logic dir
  );
    last_stage = dir ? v[scan_pkg::LAST] : v[0];
  endfunction

  // Edges seen on the synchronised clock, never on the first stage
  assign rise = st_r.sck_s2 && !st_r.sck_d;
  assign fall = !st_r.sck_s2 && st_r.sck_d;

  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.sck_s1 = shift_clock;
    st_nxt.sck_s2 = st_r.sck_s1;
    st_nxt.sck_d = st_r.sck_s2;
    st_nxt.dir_s1 = direction_select;
    st_nxt.dir_s2 = st_r.dir_s1;
    st_nxt.clr_s1 = output_clear;
    st_nxt.clr_s2 = st_r.clr_s1;
    st_nxt.p1_s1 = first_end_port_in;
    st_nxt.p1_s2 = st_r.p1_s1;
    st_nxt.p2_s1 = second_end_port_in;
    st_nxt.p2_s2 = st_r.p2_s1;
    // A full buffer holds the shift off, so no leaving bit is ever lost
    if (rise && buf_in_ready) begin
      st_nxt.chain = shift_step(st_r.chain, st_r.dir_s2,
                                st_r.dir_s2 ? st_r.p1_s2 : st_r.p2_s2);
    end
    // Gate outputs registered so clear can never glitch them
    st_nxt.gate = st_r.clr_s2 ? scan_pkg::CHAIN_RESET : st_r.chain;
    if (fall && buf_out_valid) begin
      st_nxt.out_bit = buf_data;
    end
    // Port roles follow the direction select
    st_nxt.oe2 = st_r.dir_s2;
    st_nxt.oe1 = !st_r.dir_s2;
  end

  // Bit that reaches the output end after this edge
  assign leave_bit = last_stage(shift_step(st_r.chain, st_r.dir_s2,
                                st_r.dir_s2 ? st_r.p1_s2 : st_r.p2_s2), st_r.dir_s2);

  bit_buffer2 u_out_buf (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_valid(rise),
    .in_ready(buf_in_ready),
    .in_data(leave_bit),
    .out_valid(buf_out_valid),
    .out_ready(fall),
    .out_data(buf_data)
  );

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Both end pins carry the same serial bit; only the enable differs
  assign first_end_port_out = st_r.out_bit;
  assign second_end_port_out = st_r.out_bit;
  assign first_end_port_oe = st_r.oe1;
  assign second_end_port_oe = st_r.oe2;
  assign gate_outputs = st_r.gate;

  // Checks next to the logic above
  chk_clear_forces_low: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    st_r.clr_s2 |=> (st_r.gate == scan_pkg::CHAIN_RESET))
    else $error("gate outputs not low under clear");
  chk_gate_mirror: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    !st_r.clr_s2 |=> (st_r.gate == $past(st_r.chain)))
    else $error("gate outputs do not mirror the stages");
  chk_capture_fwd: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (rise && buf_in_ready && st_r.dir_s2) |=> (st_r.chain[0] == $past(st_r.p1_s2)))
    else $error("first port not captured");
  chk_capture_rev: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (rise && buf_in_ready && !st_r.dir_s2) |=>
      (st_r.chain[scan_pkg::LAST] == $past(st_r.p2_s2)))
    else $error("second port not captured");
  chk_shift_advance: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (rise && buf_in_ready && st_r.dir_s2) |=>
      (st_r.chain[scan_pkg::LAST:1] == $past(st_r.chain[scan_pkg::LAST-1:0])))
    else $error("pattern did not advance");
  chk_hold_no_edge: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    !rise |=> $stable(st_r.chain))
    else $error("stages changed without a rising edge");
  chk_out_on_fall: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (fall && buf_out_valid) |=> (first_end_port_out == $past(buf_data)))
    else $error("serial output not updated on falling edge");
  chk_out_port_role: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    st_r.dir_s2 [*2] |=> (second_end_port_oe && !first_end_port_oe))
    else $error("port roles do not follow direction");

  // Shifts are never dropped: a full buffer would swallow a rising edge
  chk_no_lost_rise: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    rise |-> buf_in_ready)
    else $error("rising edge refused by a full buffer");
  // A pin edge must reach the edge detector within the sync latency
  chk_rise_latency: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    $rose(shift_clock) |-> ##[1:3] rise)
    else $error("rising shift clock not detected in time");
  // Reverse scans move the pattern toward the first stage
  chk_shift_reverse: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (rise && buf_in_ready && !st_r.dir_s2) |=>
      (st_r.chain[scan_pkg::LAST-1:0] == $past(st_r.chain[scan_pkg::LAST:1])))
    else $error("pattern did not move toward the first stage");
  // Clear checked from the pin, so a broken sync stage is caught too
  chk_clear_pin: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    output_clear [*3] |=> (gate_outputs == scan_pkg::CHAIN_RESET))
    else $error("gate outputs not low three cycles into clear");
  // Steady stages and steady clear must leave the gate lines alone
  chk_gate_settled: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ($stable(st_r.chain) && $stable(st_r.clr_s2)) |=> $stable(gate_outputs))
    else $error("gate outputs moved with stages and clear steady");
  // The serial bit only moves on a falling edge with a bit waiting
  chk_out_hold: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    !(fall && buf_out_valid) |=> $stable(first_end_port_out))
    else $error("serial output moved without a falling edge");
  // Select low hands the first end pin to the serial output
  chk_out_port_rev: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    !st_r.dir_s2 [*2] |=> (first_end_port_oe && !second_end_port_oe))
    else $error("first end pin not driving with select low");
  // Select high seen at the pin long enough must enable the second end
  chk_oe_follow_pin: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    direction_select [*3] |=> second_end_port_oe)
    else $error("second end pin not driving with select high");
  // Never both pins driving, or the two ends would fight
  chk_oe_exclusive: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    !(first_end_port_oe && second_end_port_oe))
    else $error("both end pins driving at once");
endmodule

// ===== sim/scan_ctrl_model.sv
/*
  Panel timing controller model: shift clock, direction, clear and start bit.
  Assumes the bench resolves each end pin from the design's output enables.
*/
`timescale 1ns/100ps
module scan_ctrl_model (
  input wire logic sys_clk,
  output logic shift_clock,
  output logic direction_select,
  output logic output_clear,
  output logic first_drv,
  output logic second_drv
);
  // Shift clock idles low between frames
  initial begin
    shift_clock = 1'b0;
    direction_select = 1'b1;
    output_clear = 1'b0;
    first_drv = 1'b0;
    second_drv = 1'b0;
  end

  // Data leads the rise by 4 cycles and holds to the fall, well past the sync pipe
  task automatic shift(input logic b);
    @(posedge sys_clk);
    if (direction_select) first_drv <= b;
    else second_drv <= b;
    repeat (4) @(posedge sys_clk);
    shift_clock <= 1'b1;
    repeat (8) @(posedge sys_clk);
    shift_clock <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask

  // Only called while the shift clock is idle, never mid-scan
  task automatic set_dir(input logic d);
    @(posedge sys_clk);
    direction_select <= d;
  endtask

  task automatic set_clear(input logic c);
    @(posedge sys_clk);
    output_clear <= c;
  endtask
endmodule

// ===== sim/tb_top.sv
/*
  Self-checking bench for the gate-scan shift register.
  Assumes a 100 MHz sys_clk and the controller model on the far side.
*/
`timescale 1ns/100ps
module tb_top;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic shift_clock, direction_select, output_clear, first_drv, second_drv;
  logic first_end_port_out, first_end_port_oe, second_end_port_out, second_end_port_oe;
  logic [scan_pkg::STAGES-1:0] gate_outputs;
  logic [scan_pkg::STAGES-1:0] ref_q = '0;
  int miscompares = 0;
  int comparisons = 0;
  // Pin level: the design wins where it drives, else the controller
  wire logic first_pin = first_end_port_oe ? first_end_port_out : first_drv;
  wire logic second_pin = second_end_port_oe ? second_end_port_out : second_drv;

  always #5 sys_clk = ~sys_clk;

  scan_ctrl_model scan_ctrl_model_i (.sys_clk(sys_clk), .shift_clock(shift_clock),
    .direction_select(direction_select), .output_clear(output_clear),
    .first_drv(first_drv), .second_drv(second_drv));

  gate_scan_shift gate_scan_shift_i (.sys_clk(sys_clk), .resetn(resetn),
    .shift_clock(shift_clock), .direction_select(direction_select),
    .output_clear(output_clear), .first_end_port_in(first_pin),
    .first_end_port_out(first_end_port_out), .first_end_port_oe(first_end_port_oe),
    .second_end_port_in(second_pin), .second_end_port_out(second_end_port_out),
    .second_end_port_oe(second_end_port_oe), .gate_outputs(gate_outputs));

  task automatic check(input logic [119:0] seen, input logic [119:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One shift, then gates, serial out and pin roles against the reference chain
  task automatic step(input logic b);
    logic d;
    logic so;
    d = direction_select;
    scan_ctrl_model_i.shift(b);
    ref_q = d ? {ref_q[118:0], b} : {b, ref_q[119:1]};
    so = d ? second_end_port_out : first_end_port_out;
    check(gate_outputs, ref_q, "gate pattern");
    check(120'(so), 120'(ref_q[d ? 119 : 0]), "serial out");
    check(120'({first_end_port_oe, second_end_port_oe}), 120'({~d, d}), "pin roles");
  endtask

  // 121 shifts so the start bit reaches the serial out and then leaves
  task automatic scan_forward();
    for (int k = 1; k <= 121; k++) step(k == 1);
  endtask

  // Clear must hide the chain without losing it
  task automatic clear_outputs();
    step(1'b1);
    step(1'b0);
    scan_ctrl_model_i.set_clear(1'b1);
    repeat (6) @(posedge sys_clk);
    check(gate_outputs, '0, "clear high");
    scan_ctrl_model_i.set_clear(1'b0);
    repeat (6) @(posedge sys_clk);
    check(gate_outputs, ref_q, "clear low");
  endtask

  // Direction turned only while idle; leftover bit exits at the first end
  task automatic scan_reverse();
    scan_ctrl_model_i.set_dir(1'b0);
    repeat (6) @(posedge sys_clk);
    for (int k = 1; k <= 121; k++) step(k == 1);
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    scan_forward();
    clear_outputs();
    scan_reverse();
    end_of_test();
  end

  // About 5,200 cycles expected; cut off well beyond that
  initial begin
    repeat (12000) @(posedge sys_clk);
    miscompares++;
    end_of_test();
  end
endmodule
